// file: rtl/spb_regs.vh
// Register map and field constants for the stream port B routing block
`ifndef SPB_REGS_VH
`define SPB_REGS_VH
// ==========================================
// Register offsets
`define SPB_OFS_STATUS 12'h0c8
`define SPB_OFS_ENABLE 12'h0cc
`define SPB_OFS_MASK 12'h0d0
`define SPB_OFS_MAP 12'h0d4
`define SPB_OFS_CTRL 12'h0e0
`define SPB_OFS_LOC_BASE 12'h100
`define SPB_OFS_LOC_LAST 12'h11c
// ==========================================
// Event bit positions, shared by status and enable
`define SPB_BIT_OVERRUN 0
`define SPB_BIT_INSERT 8
// ==========================================
// Control register bits
`define SPB_BIT_FLT_EN 0
`define SPB_BIT_INS_EN 1
// ==========================================
// Buffer map layout: location n at bits 4n+2..4n
`define SPB_MAP_STRIDE 4
`define SPB_MAP_FW 3
`define SPB_MAP_VALID 32'h77777777
// ==========================================
// Reset values
`define SPB_RST_ENABLE 32'h00000000
`define SPB_RST_MASK 32'h00000000
`define SPB_RST_MAP 32'h00000000
`define SPB_RST_LOC 32'h00000000
`define SPB_RST_BUF 3'h0
// ==========================================
// Misc
`define SPB_ZERO32 32'h00000000
`define SPB_LOC_IDX_LSB 2
`define SPB_LOC_IDX_W 3
`endif

// file: rtl/spb_top.v
// Stream port B event interrupt gating and PID buffer routing
`timescale 1ns/1ns
`include "spb_regs.vh"
// ==========================================
module spb_top #(
  parameter PID_W = 32,
  parameter DATA_W = 8,
  parameter ADDR_W = 12,
  parameter NLOC = 8
) (
  input wire mclk, // System clock
  input wire reset, // Synchronous reset, active high
  input wire [ADDR_W-1:0] reg_addr, // Register byte address
  input wire [31:0] reg_wdata, // Register write data
  input wire reg_wr, // Write strobe
  input wire reg_rd, // Read strobe
  output reg [31:0] reg_rdata_q, // Read data, cycle after strobe
  input wire ts_valid, // Incoming stream word valid
  input wire [PID_W-1:0] ts_pid, // PID of incoming word
  input wire [DATA_W-1:0] ts_data, // Incoming stream data
  input wire buf_full, // Port input buffer cannot accept
  input wire insert_done, // Inserter placed a packet
  output wire insert_enable, // Inserter allowed to run
  output reg route_valid_q, // Routed word valid
  output reg [2:0] route_buf_q, // Destination buffer index
  output reg [DATA_W-1:0] route_data_q, // Routed data
  output reg route_hit_q, // Accepted word matched a filter location, filter on
  output wire summary_port_b_irq // Summary interrupt, level
);

  // ==========================================
  // Helpers
  function [2:0] map_field;
    input [31:0] map;
    input integer n;
    begin
      map_field = map[n*`SPB_MAP_STRIDE +: `SPB_MAP_FW];
    end
  endfunction

  function pid_match;
    input [PID_W-1:0] pid;
    input [PID_W-1:0] val;
    input [PID_W-1:0] mask;
    begin
      pid_match = (((pid ^ val) & mask) == {PID_W{1'b0}});
    end
  endfunction

  function addr_is;
    input [ADDR_W-1:0] addr;
    input [ADDR_W-1:0] ofs;
    begin
      addr_is = (addr == ofs);
    end
  endfunction

  // Index of the lowest set bit; callers check for an empty vector first
  function [`SPB_LOC_IDX_W-1:0] lowest_hit;
    input [NLOC-1:0] hits;
    integer j;
    begin
      lowest_hit = {`SPB_LOC_IDX_W{1'b0}};
      for (j = NLOC - 1; j >= 0; j = j - 1) begin
        if (hits[j]) begin
          lowest_hit = j[`SPB_LOC_IDX_W-1:0];
        end
      end
    end
  endfunction

  // ==========================================
  // Register state
  reg [31:0] enable_q;
  reg [31:0] enable_d;
  reg [PID_W-1:0] mask_q;
  reg [PID_W-1:0] mask_d;
  reg [31:0] map_q;
  reg [31:0] map_d;
  reg flt_en_q;
  reg flt_en_d;
  reg ins_en_q;
  reg ins_en_d;
  reg st_overrun_q;
  reg st_overrun_d;
  reg st_insert_q;
  reg st_insert_d;
  reg [PID_W-1:0] loc_q [0:NLOC-1];
  reg [31:0] rdata_d;

  // ==========================================
  // Address decode
  wire hit_status = addr_is(reg_addr, `SPB_OFS_STATUS);
  wire hit_enable = addr_is(reg_addr, `SPB_OFS_ENABLE);
  wire hit_mask = addr_is(reg_addr, `SPB_OFS_MASK);
  wire hit_map = addr_is(reg_addr, `SPB_OFS_MAP);
  wire hit_ctrl = addr_is(reg_addr, `SPB_OFS_CTRL);
  wire hit_loc = (reg_addr >= `SPB_OFS_LOC_BASE) && (reg_addr <= `SPB_OFS_LOC_LAST) &&
    (reg_addr[1:0] == 2'h0);
  wire [ADDR_W-1:0] loc_off = reg_addr - `SPB_OFS_LOC_BASE;
  wire [`SPB_LOC_IDX_W-1:0] loc_idx = loc_off[`SPB_LOC_IDX_LSB +: `SPB_LOC_IDX_W];

  // One write enable per filter location
  reg [NLOC-1:0] loc_wr;
  integer w;
  always @* begin
    loc_wr = {NLOC{1'b0}};
    for (w = 0; w < NLOC; w = w + 1) begin
      if (reg_wr && hit_loc && (loc_idx == w)) begin
        loc_wr[w] = 1'b1;
      end
    end
  end

  // ==========================================
  // Events
  // Overrun only counts a word really offered while the buffer is full
  wire ev_overrun = ts_valid && buf_full;
  // Done pulses while the inserter is off are stray and ignored
  wire ev_insert = insert_done && ins_en_q;
  wire rd_status = reg_rd && hit_status;

  // ==========================================
  // Next state of writable registers
  always @* begin
    enable_d = enable_q;
    mask_d = mask_q;
    map_d = map_q;
    flt_en_d = flt_en_q;
    ins_en_d = ins_en_q;
    if (reg_wr && hit_enable) begin
      // Only the two event bits hold state; the rest read zero
      enable_d = `SPB_ZERO32;
      enable_d[`SPB_BIT_OVERRUN] = reg_wdata[`SPB_BIT_OVERRUN];
      enable_d[`SPB_BIT_INSERT] = reg_wdata[`SPB_BIT_INSERT];
    end
    if (reg_wr && hit_mask) begin
      mask_d = reg_wdata[PID_W-1:0];
    end
    if (reg_wr && hit_map) begin
      map_d = reg_wdata & `SPB_MAP_VALID;
    end
    if (reg_wr && hit_ctrl) begin
      flt_en_d = reg_wdata[`SPB_BIT_FLT_EN];
      ins_en_d = reg_wdata[`SPB_BIT_INS_EN];
    end
    // Hardware disable beats a same-cycle software enable, so one
    // done event never lets a second packet slip in unseen
    if (ev_insert) begin
      ins_en_d = 1'b0;
    end
  end

  // ==========================================
  // Status flags: clear on read, a same-cycle event wins
  always @* begin
    st_overrun_d = st_overrun_q;
    st_insert_d = st_insert_q;
    if (rd_status) begin
      st_overrun_d = 1'b0;
      st_insert_d = 1'b0;
    end
    if (ev_overrun) begin
      st_overrun_d = 1'b1;
    end
    if (ev_insert) begin
      st_insert_d = 1'b1;
    end
  end

  // ==========================================
  // Software images of the status and control words
  reg [31:0] status_img;
  reg [31:0] ctrl_img;
  always @* begin
    status_img = `SPB_ZERO32;
    status_img[`SPB_BIT_OVERRUN] = st_overrun_q;
    status_img[`SPB_BIT_INSERT] = st_insert_q;
    ctrl_img = `SPB_ZERO32;
    ctrl_img[`SPB_BIT_FLT_EN] = flt_en_q;
    ctrl_img[`SPB_BIT_INS_EN] = ins_en_q;
  end

  // ==========================================
  // Read mux
  always @* begin
    rdata_d = `SPB_ZERO32;
    if (reg_rd) begin
      if (hit_status) begin
        // Status shows the value before the clear takes effect
        rdata_d = status_img;
      end else if (hit_enable) begin
        rdata_d = enable_q;
      end else if (hit_mask) begin
        rdata_d[PID_W-1:0] = mask_q;
      end else if (hit_map) begin
        rdata_d = map_q;
      end else if (hit_ctrl) begin
        rdata_d = ctrl_img;
      end else if (hit_loc) begin
        rdata_d[PID_W-1:0] = loc_q[loc_idx];
      end
    end
  end

  // ==========================================
  // Register update
  always @(posedge mclk) begin
    if (reset) begin
      enable_q <= `SPB_RST_ENABLE;
    end else begin
      enable_q <= enable_d;
    end
  end

  always @(posedge mclk) begin
    if (reset) begin
      mask_q <= `SPB_RST_MASK;
    end else begin
      mask_q <= mask_d;
    end
  end

  always @(posedge mclk) begin
    if (reset) begin
      map_q <= `SPB_RST_MAP;
    end else begin
      map_q <= map_d;
    end
  end

  // Filter and inserter both start off, so until configured every accepted word routes to buffer 0 and nothing is inserted
  always @(posedge mclk) begin
    if (reset) begin
      flt_en_q <= 1'b0;
      ins_en_q <= 1'b0;
    end else begin
      flt_en_q <= flt_en_d;
      ins_en_q <= ins_en_d;
    end
  end

  always @(posedge mclk) begin
    if (reset) begin
      st_overrun_q <= 1'b0;
      st_insert_q <= 1'b0;
    end else begin
      st_overrun_q <= st_overrun_d;
      st_insert_q <= st_insert_d;
    end
  end

  // Read data stands one cycle only; the mux gives zero without a strobe
  always @(posedge mclk) begin
    if (reset) begin
      reg_rdata_q <= `SPB_ZERO32;
    end else begin
      reg_rdata_q <= rdata_d;
    end
  end

  // ==========================================
  // PID filter locations
  integer k;
  always @(posedge mclk) begin
    if (reset) begin
      for (k = 0; k < NLOC; k = k + 1) begin
        loc_q[k] <= `SPB_RST_LOC;
      end
    end else begin
      for (k = 0; k < NLOC; k = k + 1) begin
        if (loc_wr[k]) begin
          loc_q[k] <= reg_wdata[PID_W-1:0];
        end
      end
    end
  end

  // ==========================================
  // PID compare and buffer selection
  reg [NLOC-1:0] loc_hit;
  reg [`SPB_LOC_IDX_W-1:0] hit_idx;
  reg any_hit;
  reg [2:0] sel_buf;
  integer n;
  always @* begin
    loc_hit = {NLOC{1'b0}};
    for (n = 0; n < NLOC; n = n + 1) begin
      // Mask bits at zero drop out; an all-zero mask matches everything
      loc_hit[n] = pid_match(ts_pid, loc_q[n], mask_q);
    end
  end

  // Lowest matching location wins when several match
  always @* begin
    any_hit = |loc_hit;
    hit_idx = lowest_hit(loc_hit);
    sel_buf = `SPB_RST_BUF;
    if (any_hit) begin
      sel_buf = map_field(map_q, hit_idx);
    end
  end

  // ==========================================
  // Routed output
  // Lost words (buffer full) are not forwarded; with the filter on,
  // words that match no location are dropped
  wire accept = ts_valid && !buf_full;
  always @(posedge mclk) begin
    if (reset) begin
      route_valid_q <= 1'b0;
      route_buf_q <= `SPB_RST_BUF;
      route_data_q <= {DATA_W{1'b0}};
      route_hit_q <= 1'b0;
    end else begin
      route_data_q <= ts_data;
      route_hit_q <= accept && flt_en_q && any_hit;
      if (flt_en_q) begin
        route_valid_q <= accept && any_hit;
        route_buf_q <= any_hit ? sel_buf : `SPB_RST_BUF;
      end else begin
        route_valid_q <= accept;
        route_buf_q <= `SPB_RST_BUF;
      end
    end
  end

  // ==========================================
  // Interrupt
  assign insert_enable = ins_en_q;
  // Re-evaluated every cycle straight from the flags
  assign summary_port_b_irq = (st_insert_q && enable_q[`SPB_BIT_INSERT]) ||
    (st_overrun_q && enable_q[`SPB_BIT_OVERRUN]);

endmodule

// file: tb/spb_chk.sv
// Port-level checks for the stream port B block
`timescale 1ns/1ns
module spb_chk #(
  parameter DATA_W = 8,
  parameter ADDR_W = 12
) (
  input wire mclk, // Clock
  input wire reset, // Sync reset
  input wire [ADDR_W-1:0] reg_addr, // Address
  input wire reg_wr, // Write strobe
  input wire reg_rd, // Read strobe
  input wire [31:0] reg_rdata_q, // Read data
  input wire ts_valid, // Word valid
  input wire [DATA_W-1:0] ts_data, // Word data
  input wire buf_full, // Buffer full
  input wire insert_done, // Inserter done
  input wire insert_enable, // Inserter enable
  input wire route_valid_q, // Routed valid
  input wire [DATA_W-1:0] route_data_q, // Routed data
  input wire summary_port_b_irq // Summary irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  sequence s_rd(ofs);
    reg_rd && reg_addr == ofs;
  endsequence
  sequence s_ins;
    insert_done && insert_enable;
  endsequence
  a_full_drops: assert property (ts_valid && buf_full |=> !route_valid_q)
    else $error("lost word was routed");
  a_idle_route: assert property (!ts_valid |=> !route_valid_q)
    else $error("route without word");
  a_data_follow: assert property (route_valid_q |-> route_data_q == $past(ts_data))
    else $error("routed data wrong");
  a_insert_stop: assert property (s_ins |=> !insert_enable)
    else $error("inserter not disabled");
  a_insert_rise: assert property ($rose(insert_enable) |-> $past(reg_wr) && $past(reg_addr) == 12'h0e0)
    else $error("inserter enabled without write");
  a_irq_cause: assert property ($rose(summary_port_b_irq) |->
    $past(ts_valid && buf_full || insert_done || reg_wr && reg_addr == 12'h0cc))
    else $error("irq rose without cause");
  a_irq_clear: assert property (s_rd(12'h0c8) ##0 !ts_valid && !insert_done |=> !summary_port_b_irq)
    else $error("irq held after status read");
  a_enable_rsvd: assert property (s_rd(12'h0cc) |=> (reg_rdata_q & ~32'h101) == 0)
    else $error("enable reserved bits set");
  a_map_rsvd: assert property (s_rd(12'h0d4) |=> (reg_rdata_q & 32'h88888888) == 0)
    else $error("map reserved bits set");
endmodule
bind spb_top spb_chk #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) spb_chk_inst (.mclk(mclk), .reset(reset),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .ts_valid(ts_valid),
  .ts_data(ts_data), .buf_full(buf_full), .insert_done(insert_done), .insert_enable(insert_enable),
  .route_valid_q(route_valid_q), .route_data_q(route_data_q), .summary_port_b_irq(summary_port_b_irq));

// file: tb/spb_src.sv
// Stream source and inserter model facing the port B block
`timescale 1ns/1ns
module spb_src (
  input wire mclk, // Clock
  output reg ts_valid = 1'b0, // Word valid
  output reg [31:0] ts_pid = 32'h0, // Word PID
  output reg [7:0] ts_data = 8'h0, // Word data
  output reg buf_full = 1'b0, // Buffer full
  output reg insert_done = 1'b0 // Inserter done
);
  // ==========================================
  // Idle PID and data lines carry the inverse so a stale word never looks current
  task send(input [31:0] p, input [7:0] d, input f, input i);
    @(posedge mclk);
    ts_valid <= 1'b1;
    ts_pid <= p;
    ts_data <= d;
    buf_full <= f;
    insert_done <= i;
    @(posedge mclk);
    ts_valid <= 1'b0;
    ts_pid <= ~p;
    ts_data <= ~d;
    buf_full <= 1'b0;
    insert_done <= 1'b0;
    #1;
  endtask
endmodule

// file: tb/spb_top_tb_top.sv
// Self-checking bench for the stream port B block
`timescale 1ns/1ns
module spb_top_tb_top;
  reg mclk = 0;
  reg reset = 1;
  reg [11:0] a = 0;
  reg [31:0] wd = 0;
  reg wr = 0;
  reg rd = 0;
  wire [31:0] rdq, tp;
  wire tv, tf, ti, ie, rv, rh, irq;
  wire [7:0] td, rdat;
  wire [2:0] rb;
  int errors = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [31:0] seed = 87, q, msk, map, p, eb, hit, lv[8];
  logic flt, full;
  spb_top spb_top_inst (.mclk(mclk), .reset(reset), .reg_addr(a), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd),
    .reg_rdata_q(rdq), .ts_valid(tv), .ts_pid(tp), .ts_data(td), .buf_full(tf), .insert_done(ti),
    .insert_enable(ie), .route_valid_q(rv), .route_buf_q(rb), .route_data_q(rdat), .route_hit_q(rh),
    .summary_port_b_irq(irq));
  spb_src spb_src_inst (.mclk(mclk), .ts_valid(tv), .ts_pid(tp), .ts_data(td), .buf_full(tf), .insert_done(ti));
  // ==========================================
  // Helpers
  function automatic [31:0] lf(input [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, s, e);
    end
  endtask
  task wreg(input [11:0] ad, input [31:0] d);
    @(posedge mclk);
    wr <= 1;
    a <= ad;
    wd <= d;
    @(posedge mclk);
    wr <= 0;
    #1;
  endtask
  task rchk(input [11:0] ad, input [31:0] e);
    @(posedge mclk);
    rd <= 1;
    a <= ad;
    @(posedge mclk);
    rd <= 0;
    #1 q = rdq;
    chk(q, e);
  endtask
  task wrap_up;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      errors++;
      wrap_up;
    end
  end
  // ==========================================
  // Main sequence
  initial begin
    repeat (10) @(posedge mclk);
    reset <= 0;
    rchk(12'h0cc, 0);
    rchk(12'h0d0, 0);
    rchk(12'h0d4, 0);
    wreg(12'h0cc, 32'hffffffff);
    rchk(12'h0cc, 32'h101);
    wreg(12'h0d4, 32'hffffffff);
    rchk(12'h0d4, 32'h77777777);
    rchk(12'h0f0, 0);
    wreg(12'h0cc, 0);
    spb_src_inst.send(0, 0, 1, 0);
    chk(irq, 0);
    rchk(12'h0c8, 1);
    rchk(12'h0c8, 0);
    wreg(12'h0cc, 1);
    spb_src_inst.send(0, 0, 1, 0);
    chk(irq, 1);
    rchk(12'h0c8, 1);
    chk(irq, 0);
    wreg(12'h0cc, 32'h100);
    wreg(12'h0e0, 2);
    chk(ie, 1);
    rchk(12'h0e0, 2);
    spb_src_inst.send(0, 0, 0, 1);
    chk(ie, 0);
    chk(irq, 1);
    rchk(12'h0c8, 32'h100);
    // A done pulse while the inserter is off must leave status alone
    spb_src_inst.send(0, 0, 0, 1);
    rchk(12'h0c8, 0);
    chk(irq, 0);
    rchk(12'h0e0, 0);
    // Mid-run reset must bring enables and map back to zero
    @(posedge mclk);
    reset <= 1;
    repeat (2) @(posedge mclk);
    reset <= 0;
    rchk(12'h0cc, 0);
    rchk(12'h0d4, 0);
    for (int n = 0; n < 8; n++) begin
      seed = lf(seed);
      lv[n] = seed;
      wreg(12'h100 + 12'(4 * n), seed);
      rchk(12'h100 + 12'(4 * n), seed);
    end
    for (int i = 0; i < 64; i++) begin
      seed = lf(seed);
      msk = i % 4 == 0 ? 0 : i % 4 == 1 ? 32'hffffffff : seed;
      map = lf(seed) & 32'h77777777;
      flt = seed[3];
      wreg(12'h0d0, msk);
      rchk(12'h0d0, msk);
      wreg(12'h0d4, map);
      wreg(12'h0e0, {31'h0, flt});
      seed = lf(seed);
      p = seed[4] ? lv[seed[2:0]] ^ (seed & ~msk) : seed;
      full = seed[7:5] == 0;
      hit = 0;
      eb = 0;
      for (int n = 7; n >= 0; n--) begin
        if (flt && ((p ^ lv[n]) & msk) == 0) begin
          hit = 1;
          eb = map >> (4 * n) & 7;
        end
      end
      spb_src_inst.send(p, seed[15:8], full, 0);
      chk(rv, !full && (!flt || hit));
      if (rv === 1) begin
        chk(rb, eb);
        chk(rh, hit);
        chk(rdat, seed[15:8]);
      end
    end
    wrap_up;
  end
endmodule
